/* File: include/trib_rx_pkg.sv */
// Purpose: Shared constants and carriers for the tributary receive front end.
// Assumes: One system clock pclk at 20 MHz; all line pins are asynchronous to it.
// Notes:   Register indices are word indices; the byte address is four times the index.
//
// Behaviour
// RULE1 - Seven independent receive channels, each with its own clock, sync and data pins.
// RULE2 - Far end supplies a nominal 1.544 MHz line clock in asynchronous mapping.
// RULE3 - One global edge-select bit, bit 6 of global control, picks every active edge.
// RULE4 - Mapping mode 10 turns the channel line clock pin into an output from slip timing.
// RULE5 - Sync pin carries 3.0 ms multiframe sync, inbound normally, outbound in mode 10.
// RULE6 - Edge-select 0 samples the sync input on the falling line clock edge.
// RULE7 - Mapping mode 10 drives the sync pin as an output derived from slip timing.
// RULE8 - Edge-select 0 samples positive rail or NRZ data on the falling edge.
// RULE9 - NRZ polarity bit 4 set makes a low data level read as logic one.
// RULE10 - Edge-select 0 samples the negative rail on the falling edge.
// RULE11 - Negative rail used as violation input is counted on the selected edge.
// RULE12 - Edge-select 1 samples all sync and data inputs on the rising edge instead.
package trib_rx_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [9:0]  GLOBAL_CTRL_IDX    = 10'h007;
    localparam logic [9:0]  CHAN_CTRL_IDX_BASE = 10'h020;
    localparam logic [9:0]  CHAN_STAT_IDX_BASE = 10'h030;
    localparam int          EDGE_SEL_BIT       = 6;
    localparam int          NRZ_POL_BIT        = 4;
    localparam int          MODE_LSB           = 0;
    localparam int          NRZ_MODE_BIT       = 2;
    localparam int          CV_EN_BIT          = 3;
    localparam int          STAT_DATA_BIT      = 16;
    localparam int          STAT_SYNC_BIT      = 17;
    localparam logic [1:0]  MODE_RESET         = 2'h0;
    localparam logic [31:0] UNMAPPED_READ      = 32'h0000_0000;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          MF_SYNC_US         = 3000;
    localparam int          LINE_RATE_KHZ      = 1544;
    localparam int          MF_LINE_BITS       = MF_SYNC_US * LINE_RATE_KHZ / 1000;
    localparam int          MF_CNT_W           = 13;
    localparam int          CV_CNT_W           = 16;

    typedef enum logic [1:0] {
        MAP_ASYNC      = 2'h0,
        MAP_BYTE_SYNC  = 2'h1,
        MAP_SLIP_BUF   = 2'h2,
        MAP_SPARE      = 2'h3
    } map_mode_e;

    typedef struct packed {
        logic [1:0]          s_lclk;
        logic [1:0]          s_lo;
        logic [1:0]          s_pos;
        logic [1:0]          s_neg;
        logic [1:0]          s_sync;
        logic                lclk_d;
        logic                lo_d;
        logic [MF_CNT_W-1:0] mf_cnt;
        logic                data;
        logic                neg;
        logic                sync;
        logic                valid;
        logic [CV_CNT_W-1:0] cv;
        logic                clk_out;
        logic                clk_oe_n;
        logic                sync_out;
        logic                sync_oe_n;
    } chan_state_s;

    typedef struct packed {
        logic                edge_sel;
        logic                nrz_pol;
    } global_cfg_s;

    typedef struct packed {
        logic [1:0]          mode;
        logic                nrz_mode;
        logic                cv_en;
    } chan_cfg_s;

endpackage

/* File: rtl/trib_rx_chan.sv */
// Purpose: One tributary receive channel: pin synchronisers, edge pick, sampling, slip outputs.
// Assumes: Line pins are asynchronous to pclk and slower than a quarter of it.
// Notes:   All state lives in one packed struct registered once per clock.
`timescale 1ns/1ps
module trib_rx_chan
    import trib_rx_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire global_cfg_s         gcfg,
    input  wire chan_cfg_s           ccfg,
    input  wire logic                cv_clear,
    input  wire logic                lclk_pin,
    input  wire logic                lo_pin,
    input  wire logic                pos_pin,
    input  wire logic                neg_pin,
    input  wire logic                sync_pin,
    output chan_state_s              st
);

    chan_state_s q;
    chan_state_s next_q;
    logic        slip;
    logic        clk_now;
    logic        clk_prev;
    logic        hit;
    logic        lo_rise;
    logic        cv_hit;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************************************
    // Sampling logic
    // ****************************************************************
    always_comb begin
        next_q        = q;
        next_q.s_lclk = {q.s_lclk[0], lclk_pin};
        next_q.s_lo   = {q.s_lo[0], lo_pin};
        next_q.s_pos  = {q.s_pos[0], pos_pin};
        next_q.s_neg  = {q.s_neg[0], neg_pin};
        next_q.s_sync = {q.s_sync[0], sync_pin};
        next_q.lclk_d = q.s_lclk[1];
        next_q.lo_d   = q.s_lo[1];
        slip          = (ccfg.mode == MAP_SLIP_BUF);
        // In slip mode the channel runs on the timing it drives out itself.
        clk_now       = slip ? q.s_lo[1] : q.s_lclk[1];
        clk_prev      = slip ? q.lo_d : q.lclk_d;
        hit           = gcfg.edge_sel ? (clk_now & ~clk_prev)
                                      : (~clk_now & clk_prev); // [RULE3] [RULE12]
        lo_rise       = q.s_lo[1] & ~q.lo_d;
        cv_hit        = hit & ccfg.cv_en & q.s_neg[1];
        next_q.valid  = hit;
        if (hit) begin
            next_q.data = ccfg.nrz_mode ? (q.s_pos[1] ^ gcfg.nrz_pol)
                                        : q.s_pos[1]; // [RULE8] [RULE9]
            next_q.neg  = q.s_neg[1]; // [RULE10]
            next_q.sync = slip ? q.sync_out : q.s_sync[1]; // [RULE6] [RULE5]
        end
        // A violation landing on the clearing read is kept, not lost.
        if (cv_clear) begin
            next_q.cv = cv_hit ? CV_CNT_W'(1) : '0; // [RULE11]
        end else if (cv_hit && (q.cv != {CV_CNT_W{1'b1}})) begin
            next_q.cv = q.cv + CV_CNT_W'(1); // [RULE11]
        end
        if (!slip) begin
            next_q.mf_cnt   = '0;
            next_q.sync_out = 1'b0;
        end else if (lo_rise) begin
            if (q.mf_cnt == MF_CNT_W'(MF_LINE_BITS - 1)) begin
                next_q.mf_cnt   = '0;
                next_q.sync_out = 1'b1; // [RULE7] [RULE5]
            end else begin
                next_q.mf_cnt   = q.mf_cnt + MF_CNT_W'(1);
                next_q.sync_out = 1'b0;
            end
        end
        next_q.clk_out   = slip & q.s_lo[1]; // [RULE4]
        next_q.clk_oe_n  = ~slip; // [RULE4]
        next_q.sync_oe_n = ~slip; // [RULE7]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.clk_oe_n  <= 1'b1;
            q.sync_oe_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign st = q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_fall_sample: assert property ( // [RULE6]
        (!gcfg.edge_sel && !slip && !q.s_lclk[1] && q.lclk_d) |=> q.valid)
        else $error("falling line clock edge not sampled");
    chk_rise_sample: assert property ( // [RULE12]
        (gcfg.edge_sel && !slip && q.s_lclk[1] && !q.lclk_d) |=> q.valid)
        else $error("rising line clock edge not sampled");
    chk_pos_polarity: assert property ( // [RULE9]
        (q.valid && ccfg.nrz_mode && $stable(gcfg.nrz_pol) && $stable(ccfg))
        |-> q.data == ($past(q.s_pos[1]) ^ gcfg.nrz_pol))
        else $error("NRZ data polarity wrong");
    chk_neg_capture: assert property ( // [RULE10]
        q.valid |-> q.neg == $past(q.s_neg[1]))
        else $error("negative rail not captured at sample edge");
    chk_sync_capture: assert property ( // [RULE6]
        (q.valid && !slip && $stable(ccfg.mode)) |-> q.sync == $past(q.s_sync[1]))
        else $error("sync input not captured at sample edge");
    chk_cv_count: assert property ( // [RULE11]
        (cv_hit && !cv_clear && q.cv != {CV_CNT_W{1'b1}}) |=> q.cv == $past(q.cv) + 1)
        else $error("violation not counted");
    chk_clk_drive: assert property ( // [RULE4]
        (slip ##1 slip) |-> (!q.clk_oe_n && q.clk_out == $past(q.s_lo[1])))
        else $error("line clock pin not driven from slip timing");
    chk_sync_dir: assert property ( // [RULE7]
        !slip |=> (q.sync_oe_n && !q.sync_out))
        else $error("sync pin driven outside slip mode");

endmodule

/* File: rtl/trib_rx_front.sv */
// Purpose: Seven-channel tributary receive front end with an APB register slave.
// Assumes: APB master per the published protocol; all line pins asynchronous to pclk.
// Notes:   Every APB answer takes exactly one wait state.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module trib_rx_front
    import trib_rx_pkg::*;
#(
    parameter int NUM_CHANNELS = 7
)(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [11:0]             paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [31:0]             pwdata,
    output logic                         pready,
    output logic [31:0]                  prdata,
    output logic                         pslverr,
    input  wire logic                    slip_buffer_timing_pin,
    input  wire logic [NUM_CHANNELS-1:0] line_rx_clock_in,
    output logic [NUM_CHANNELS-1:0]      line_rx_clock_out,
    output logic [NUM_CHANNELS-1:0]      line_rx_clock_oe_n,
    input  wire logic [NUM_CHANNELS-1:0] rx_multiframe_sync_in,
    output logic [NUM_CHANNELS-1:0]      rx_multiframe_sync_out,
    output logic [NUM_CHANNELS-1:0]      rx_multiframe_sync_oe_n,
    input  wire logic [NUM_CHANNELS-1:0] rx_data_positive_rail,
    input  wire logic [NUM_CHANNELS-1:0] rx_data_negative_rail,
    output logic [NUM_CHANNELS-1:0]      rx_bit,
    output logic [NUM_CHANNELS-1:0]      rx_neg_bit,
    output logic [NUM_CHANNELS-1:0]      rx_sync_bit,
    output logic [NUM_CHANNELS-1:0]      rx_bit_valid
);

    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 16) begin : g_bad_channels
        $error("NUM_CHANNELS must be 1 to 16");
    end

    typedef struct packed {
        global_cfg_s                    gcfg;
        chan_cfg_s [NUM_CHANNELS-1:0]   ccfg;
        logic                           pready;
        logic                           pslverr;
        logic [31:0]                    prdata;
    } regs_s;

    regs_s                          q;
    regs_s                          next_q;
    chan_state_s [NUM_CHANNELS-1:0] ch;
    logic [NUM_CHANNELS-1:0]        cv_clear;
    logic [9:0]                     idx;
    logic                           access;
    logic                           done;
    logic                           hit_any;
    logic [31:0]                    rd;

    assign idx    = paddr[11:2];
    assign access = psel & penable;
    assign done   = access & q.pready;

    // ****************************************************************
    // Register slave
    // ****************************************************************
    always_comb begin
        next_q   = q;
        cv_clear = '0;
        hit_any  = 1'b0;
        rd       = UNMAPPED_READ;
        if (idx == GLOBAL_CTRL_IDX) begin
            hit_any                = 1'b1;
            rd[EDGE_SEL_BIT]       = q.gcfg.edge_sel;
            rd[NRZ_POL_BIT]        = q.gcfg.nrz_pol;
        end
        for (int i = 0; i < NUM_CHANNELS; i++) begin
            if (idx == CHAN_CTRL_IDX_BASE + 10'(i)) begin
                hit_any                     = 1'b1;
                rd[MODE_LSB +: 2]           = q.ccfg[i].mode;
                rd[NRZ_MODE_BIT]            = q.ccfg[i].nrz_mode;
                rd[CV_EN_BIT]               = q.ccfg[i].cv_en;
            end
            if (idx == CHAN_STAT_IDX_BASE + 10'(i)) begin
                hit_any                     = 1'b1;
                rd[CV_CNT_W-1:0]            = ch[i].cv;
                rd[STAT_DATA_BIT]           = ch[i].data;
                rd[STAT_SYNC_BIT]           = ch[i].sync;
                // Reading the status word restarts the violation count.
                cv_clear[i]                 = done & ~pwrite;
            end
        end
        next_q.pready = access & ~q.pready;
        if (access && !q.pready) begin
            next_q.pslverr = ~hit_any;
            next_q.prdata  = pwrite ? UNMAPPED_READ : rd;
        end else if (done) begin
            next_q.pslverr = 1'b0;
            next_q.prdata  = UNMAPPED_READ;
        end
        if (done && pwrite) begin
            if (idx == GLOBAL_CTRL_IDX) begin
                next_q.gcfg.edge_sel = pwdata[EDGE_SEL_BIT]; // [RULE3]
                next_q.gcfg.nrz_pol  = pwdata[NRZ_POL_BIT]; // [RULE9]
            end
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                if (idx == CHAN_CTRL_IDX_BASE + 10'(i)) begin
                    next_q.ccfg[i].mode     = pwdata[MODE_LSB +: 2]; // [RULE4] [RULE7]
                    next_q.ccfg[i].nrz_mode = pwdata[NRZ_MODE_BIT];
                    next_q.ccfg[i].cv_en    = pwdata[CV_EN_BIT]; // [RULE11]
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign pready  = q.pready;
    assign pslverr = q.pslverr;
    assign prdata  = q.prdata;

    // ****************************************************************
    // Channels
    // ****************************************************************
    for (genvar n = 0; n < NUM_CHANNELS; n++) begin : g_chan // [RULE1]
        trib_rx_chan u_chan (
            .pclk     (pclk),
            .presetn  (presetn),
            .gcfg     (q.gcfg),
            .ccfg     (q.ccfg[n]),
            .cv_clear (cv_clear[n]),
            .lclk_pin (line_rx_clock_in[n]),
            .lo_pin   (slip_buffer_timing_pin),
            .pos_pin  (rx_data_positive_rail[n]),
            .neg_pin  (rx_data_negative_rail[n]),
            .sync_pin (rx_multiframe_sync_in[n]),
            .st       (ch[n])
        );
        assign line_rx_clock_out[n]       = ch[n].clk_out;
        assign line_rx_clock_oe_n[n]      = ch[n].clk_oe_n;
        assign rx_multiframe_sync_out[n]  = ch[n].sync_out;
        assign rx_multiframe_sync_oe_n[n] = ch[n].sync_oe_n;
        assign rx_bit[n]                  = ch[n].data;
        assign rx_neg_bit[n]              = ch[n].neg;
        assign rx_sync_bit[n]             = ch[n].sync;
        assign rx_bit_valid[n]            = ch[n].valid;
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    chk_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) ##1 (psel && penable) |=> pready ##1 !pready)
        else $error("APB answer not after one wait state");
    chk_edge_write: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
        (done && pwrite && idx == GLOBAL_CTRL_IDX) |=> q.gcfg.edge_sel == $past(pwdata[6]))
        else $error("edge select not written");

endmodule

/* File: verification/trib_line_model.sv */
// Purpose: Far-end line receiver model driving seven tributary clock, sync and data pins.
// Assumes: The clock half period is HALF pclk cycles, well below pclk/4 in rate.
// Notes:   Data move on the edge opposite the sampling edge, so they are stable when taken.
`timescale 1ns/1ps
module trib_line_model #(
    parameter int HALF = 6
)(
    input  wire logic  pclk,
    input  wire logic  presetn,
    input  wire logic  run,
    input  wire logic  edge_sel,
    input  wire logic  neg_hi,
    output logic [6:0] lclk,
    output logic [6:0] pos,
    output logic [6:0] neg,
    output logic [6:0] sync,
    output logic [6:0] exp_pos,
    output logic [6:0] exp_neg,
    output logic [6:0] exp_sync,
    output int         edges
);
    logic [15:0] lfsr;
    logic [6:0]  neg_r;
    logic [2:0]  frame;
    int          cnt;

    // Forcing the rail high at once lets every sampled edge count as a violation.
    assign neg = neg_hi ? 7'h7f : neg_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {lclk, pos, neg_r, sync, exp_pos, exp_neg, exp_sync} <= '0;
            lfsr  <= 16'hace1;
            frame <= 3'h0;
            cnt   <= 0;
            edges <= 0;
        end else if (run) begin
            cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
            if (cnt == HALF - 1) begin
                lclk <= ~lclk;
                if (~lclk[0] == edge_sel) begin
                    exp_pos  <= pos;
                    exp_neg  <= neg;
                    exp_sync <= sync;
                    edges    <= edges + 1;
                end else begin
                    lfsr  <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
                    pos   <= lfsr[6:0];
                    neg_r <= lfsr[13:7];
                    sync  <= (frame == 3'h0) ? 7'h7f : 7'h00;
                    frame <= frame + 3'h1;
                end
            end
        end
    end
endmodule

/* File: verification/ds1_tributary_receive_input_tb_top.sv */
// Purpose: Self-checking bench for the seven-channel tributary receive front end.
// Assumes: APB master with one-wait-state slave; far end modelled by trib_line_model.
// Notes:   Line expectations come from the model's own launched values, never from outputs.
`timescale 1ns/1ps
module ds1_tributary_receive_input_tb_top
    import trib_rx_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        lo_run, model_run, model_es, neg_hi, mon_on;
    logic        slip = 1'b0, slip_q = 1'b0, co_q = 1'b0, so_q = 1'b0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  lo_div = 3'h0;
    logic [6:0]  m_lclk, m_pos, m_neg, m_sync, exp_pos, exp_neg, exp_sync, inv, mon_mask;
    logic [6:0]  clk_out, clk_oe_n, sync_out, sync_oe_n, rx_bit, rx_neg_bit, rx_sync_bit, valid;
    int          num_errors, comparisons, valids, edges, ecv;
    int          lo_rises, co_rises, sync_rises, lo_at, lo_prev, co_at, co_prev;
    wire  [6:0]  clk_wire  = (clk_oe_n & m_lclk) | (~clk_oe_n & clk_out);
    wire  [6:0]  sync_wire = (sync_oe_n & m_sync) | (~sync_oe_n & sync_out);

    trib_rx_front #(.NUM_CHANNELS(7)) u_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .slip_buffer_timing_pin(slip), .line_rx_clock_in(clk_wire),
        .line_rx_clock_out(clk_out), .line_rx_clock_oe_n(clk_oe_n),
        .rx_multiframe_sync_in(sync_wire), .rx_multiframe_sync_out(sync_out),
        .rx_multiframe_sync_oe_n(sync_oe_n), .rx_data_positive_rail(m_pos),
        .rx_data_negative_rail(m_neg), .rx_bit(rx_bit), .rx_neg_bit(rx_neg_bit),
        .rx_sync_bit(rx_sync_bit), .rx_bit_valid(valid));

    trib_line_model #(.HALF(6)) u_line (
        .pclk(pclk), .presetn(presetn), .run(model_run), .edge_sel(model_es),
        .neg_hi(neg_hi), .lclk(m_lclk), .pos(m_pos), .neg(m_neg), .sync(m_sync),
        .exp_pos(exp_pos), .exp_neg(exp_neg), .exp_sync(exp_sync), .edges(edges));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic results();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        comparisons++;
        if (seen !== expected) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            num_errors++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp, input logic exp_err);
        apb(1'b0, idx, 32'h0);
        check(rd, exp);
        check(32'(err), 32'(exp_err));
    endtask

    // Every model sampling edge must yield exactly one valid pulse on each watched channel.
    task automatic sample_run(input int cycles);
        int v0;
        int e0;
        v0 = valids;
        e0 = edges;
        model_run <= 1'b1;
        repeat (cycles) @(posedge pclk);
        model_run <= 1'b0;
        repeat (20) @(posedge pclk);
        check(32'(valids - v0), 32'((edges - e0) * $countones(mon_mask)));
    endtask

    // ****************************************************************
    // Monitors and timing pin
    // ****************************************************************
    always @(posedge pclk) begin
        if (lo_run) begin
            lo_div <= lo_div + 3'h1;
            if (lo_div == 3'h3 || lo_div == 3'h7) slip <= ~slip;
        end
    end

    always @(posedge pclk) begin
        slip_q <= slip;
        co_q   <= clk_out[2];
        so_q   <= sync_out[2];
        if (slip && !slip_q) lo_rises++;
        if (clk_out[2] && !co_q) co_rises++;
        if (sync_out[2] && !so_q) begin
            lo_prev = lo_at;
            lo_at   = lo_rises;
            co_prev = co_at;
            co_at   = co_rises;
            sync_rises++;
        end
        for (int n = 0; n < 7; n++) begin
            if (mon_on && mon_mask[n] && valid[n] === 1'b1) begin
                valids++;
                check(32'(rx_bit[n]), 32'(exp_pos[n] ^ inv[n]));
                check(32'(rx_neg_bit[n]), 32'(exp_neg[n]));
                check(32'(rx_sync_bit[n]), 32'(exp_sync[n]));
            end
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {presetn, psel, penable, pwrite, lo_run, model_run, model_es} = '0;
        {neg_hi, mon_on} = '0;
        {paddr, pwdata, inv} = '0;
        mon_mask = 7'h7f;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check(32'(clk_oe_n), 32'h7f);
        check(32'(sync_oe_n), 32'h7f);
        rchk(GLOBAL_CTRL_IDX, 32'h0, 1'b0);
        rchk(CHAN_CTRL_IDX_BASE, 32'h0, 1'b0);
        rchk(10'h3ff, UNMAPPED_READ, 1'b1);
        apb(1'b1, 10'h3ff, 32'hffff_ffff);
        check(32'(err), 32'h1);
        mon_on <= 1'b1;
        sample_run(400);
        neg_hi <= 1'b1;
        apb(1'b1, CHAN_CTRL_IDX_BASE + 10'h4, 32'h8);
        apb(1'b0, CHAN_STAT_IDX_BASE + 10'h4, 32'h0);
        ecv = edges;
        sample_run(200);
        apb(1'b0, CHAN_STAT_IDX_BASE + 10'h4, 32'h0);
        check(32'(rd[15:0]), 32'(edges - ecv));
        check(32'(rd[16]), 32'(exp_pos[4]));
        apb(1'b0, CHAN_STAT_IDX_BASE + 10'h4, 32'h0);
        check(32'(rd[15:0]), 32'h0);
        neg_hi <= 1'b0;
        apb(1'b1, GLOBAL_CTRL_IDX, 32'h10);
        apb(1'b1, CHAN_CTRL_IDX_BASE, 32'h4);
        inv <= 7'h01;
        sample_run(300);
        apb(1'b1, GLOBAL_CTRL_IDX, 32'h50);
        rchk(GLOBAL_CTRL_IDX, 32'h50, 1'b0);
        model_es <= 1'b1;
        sample_run(300);
        apb(1'b1, CHAN_CTRL_IDX_BASE + 10'h2, 32'h2);
        mon_mask <= 7'h7b;
        lo_run <= 1'b1;
        repeat (10) @(posedge pclk);
        check(32'(clk_oe_n), 32'h7b);
        check(32'(sync_oe_n), 32'h7b);
        sample_run(300);
        for (int k = 0; k < 80000 && sync_rises < 2; k++) @(posedge pclk);
        if (sync_rises < 2) begin
            num_errors++;
            results();
        end
        check(32'(lo_at - lo_prev), 32'(3000 * 1544 / 1000));
        check(32'(co_at - co_prev), 32'(3000 * 1544 / 1000));
        results();
    end
endmodule
